// file: rtl/bridge_fault_pkg.sv
package bridge_fault_pkg;

   // ****************************************************************
   // geometry of the six half-bridges
   // ****************************************************************
   localparam int unsigned BRIDGE_COUNT  = 6;
   localparam int unsigned SWITCH_COUNT  = 2 * BRIDGE_COUNT;
   localparam int unsigned LOW_BANK_BITS = 8;    // bridges 1 to 4
   localparam int unsigned HIGH_BANK_LSB = 8;    // bridges 5 to 6 start here
   localparam int unsigned HIGH_BANK_W   = 4;

   // ****************************************************************
   // serial command layout
   // ****************************************************************
   localparam int unsigned BYTE_BITS      = 8;
   localparam int unsigned FRAME_BITS     = 16;
   localparam int unsigned CNT_W          = 5;
   localparam int unsigned CLEAR_SEL_BIT  = 7;   // read_clear_select_bit position
   localparam int unsigned ADDR_HI_BIT    = 6;
   localparam int unsigned ADDR_LO_BIT    = 2;
   localparam int unsigned ADDR_EXT_BIT   = 1;   // address_extension_bit position
   localparam int unsigned ADDR_TAIL_BIT  = 0;
   localparam int unsigned SUMMARY_BIT    = 6;   // load_error_summary in status byte

   // ****************************************************************
   // address codes (bits 6..2 of the address byte)
   // ****************************************************************
   localparam logic [4:0] ADDR_OC_1_TO_4 = 5'h16;   // 101 10
   localparam logic [4:0] ADDR_OC_5_TO_6 = 5'h0e;   // 011 10
   localparam logic [4:0] ADDR_OL_1_TO_4 = 5'h01;   // 000 01
   localparam logic [4:0] ADDR_OL_5_TO_6 = 5'h11;   // 100 01
   localparam logic       ADDR_EXT_VAL   = 1'b0;
   localparam logic       ADDR_TAIL_VAL  = 1'b1;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0]  STATUS_RESET = 8'h00;
   localparam logic [11:0] FLAGS_RESET  = 12'h000;
   localparam logic [3:0]  RESERVED_VAL = 4'h0;

   // register selected by a command
   typedef enum logic [2:0] {
      SEL_NONE  = 3'b000,
      SEL_OC_LO = 3'b001,
      SEL_OC_HI = 3'b010,
      SEL_OL_LO = 3'b011,
      SEL_OL_HI = 3'b100
   } reg_sel_e;

   typedef enum logic [0:0] {
      LINK_IDLE  = 1'b0,
      LINK_FRAME = 1'b1
   } link_state_e;

endpackage

// file: rtl/level_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for levels arriving from outside the clock domain
module level_sync #(
   parameter int unsigned WIDTH     = 1,
   parameter logic        RESET_VAL = 1'b0
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= {WIDTH{RESET_VAL}};
         sync_o <= {WIDTH{RESET_VAL}};
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule

// file: rtl/bridge_fault_status_bank.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1: summary bit is OR of all flags
// RULE2: summary read-only, falls when all flags cleared
// RULE3: first overcurrent register, bridges 1-4 layout
// RULE4: second overcurrent register, bridges 6-5 low bits
// RULE5: first open-load register, same layout
// RULE6: second open-load register, bridges 6-5 low bits
// RULE7: overcurrent latches flag and disables that switch
// RULE8: open load latches flag until host clears
// RULE9: every flag resets to zero
// RULE10: upper four bits of second registers read zero
// RULE11: 16-bit command, address bit 7 selects clear
// RULE12: flags only cleared by host command
// RULE13: all status registers zero after reset
// RULE14: new fault wins over simultaneous clear
module bridge_fault_status_bank
   import bridge_fault_pkg::*;
(
   input  wire logic                                sys_clk_i,
   input  wire logic                                reset_n_i,
   input  wire logic                                spi_cs_n_i,
   input  wire logic                                spi_sclk_i,
   input  wire logic                                spi_sdi_i,
   output logic                                     spi_sdo_o,
   output logic                                     spi_sdo_oe_o,
   input  wire logic [bridge_fault_pkg::SWITCH_COUNT-1:0] overcurrent_detect_i,
   input  wire logic [bridge_fault_pkg::SWITCH_COUNT-1:0] open_load_detect_i,
   output logic [bridge_fault_pkg::BRIDGE_COUNT-1:0] high_side_disable_o,
   output logic [bridge_fault_pkg::BRIDGE_COUNT-1:0] low_side_disable_o,
   output logic                                     load_error_summary_o
);
   import bridge_fault_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      link_state_e              link;
      logic                     sclk_prev;
      logic                     cs_n_prev;
      logic [CNT_W-1:0]         bit_cnt;
      logic [FRAME_BITS-1:0]    rx;
      logic [BYTE_BITS-1:0]     tx;
      logic [SWITCH_COUNT-1:0]  oc;     // index 2(k-1) low side, 2k-1 high side
      logic [SWITCH_COUNT-1:0]  ol;
      logic                     sdo;
      logic                     sdo_oe;
      logic                     summary;
   } state_s;

   state_s state_q;
   state_s state_d;

   logic                    cs_n_s;
   logic                    sclk_s;
   logic                    sdi_s;
   logic [SWITCH_COUNT-1:0] oc_det_s;
   logic [SWITCH_COUNT-1:0] ol_det_s;

   // ****************************************************************
   // synchronisers
   // ****************************************************************
   // chip select idles high, so its stages reset high to avoid a false frame
   level_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_cs (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (spi_cs_n_i),
      .sync_o    (cs_n_s)
   );

   level_sync #(.WIDTH(2), .RESET_VAL(1'b0)) u_sync_link (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({spi_sclk_i, spi_sdi_i}),
      .sync_o    ({sclk_s, sdi_s})
   );

   // detectors are analog comparators, asynchronous to this clock
   level_sync #(.WIDTH(2 * SWITCH_COUNT), .RESET_VAL(1'b0)) u_sync_det (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({overcurrent_detect_i, open_load_detect_i}),
      .sync_o    ({oc_det_s, ol_det_s})
   );

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   // address byte to register select; bit 0 and the extension bit must match
   function automatic reg_sel_e decode_addr(input logic [BYTE_BITS-1:0] abyte);
      reg_sel_e sel;
      sel = SEL_NONE;
      if (abyte[ADDR_TAIL_BIT] == ADDR_TAIL_VAL && abyte[ADDR_EXT_BIT] == ADDR_EXT_VAL) begin
         case (abyte[ADDR_HI_BIT:ADDR_LO_BIT])
            ADDR_OC_1_TO_4: sel = SEL_OC_LO;  // RULE3
            ADDR_OC_5_TO_6: sel = SEL_OC_HI;  // RULE4
            ADDR_OL_1_TO_4: sel = SEL_OL_LO;  // RULE5
            ADDR_OL_5_TO_6: sel = SEL_OL_HI;  // RULE6
            default:        sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   // mask of flag bits covered by one register
   function automatic logic [SWITCH_COUNT-1:0] bank_mask(input logic hi);
      bank_mask = hi ? {{HIGH_BANK_W{1'b1}}, {LOW_BANK_BITS{1'b0}}}
                     : {{HIGH_BANK_W{1'b0}}, {LOW_BANK_BITS{1'b1}}};
   endfunction

   // read value of the selected register; unmapped addresses read zero
   function automatic logic [BYTE_BITS-1:0] read_value(input reg_sel_e sel,
                                                      input logic [SWITCH_COUNT-1:0] oc,
                                                      input logic [SWITCH_COUNT-1:0] ol);
      case (sel)
         SEL_OC_LO: read_value = oc[LOW_BANK_BITS-1:0];                              // RULE3
         SEL_OC_HI: read_value = {RESERVED_VAL, oc[HIGH_BANK_LSB +: HIGH_BANK_W]};   // RULE4 RULE10
         SEL_OL_LO: read_value = ol[LOW_BANK_BITS-1:0];                              // RULE5
         SEL_OL_HI: read_value = {RESERVED_VAL, ol[HIGH_BANK_LSB +: HIGH_BANK_W]};   // RULE6 RULE10
         default:   read_value = STATUS_RESET;
      endcase
   endfunction

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic                    sclk_rise;
      logic                    sclk_fall;
      logic                    cs_fall;
      logic                    cs_rise;
      logic [SWITCH_COUNT-1:0] oc_clr;
      logic [SWITCH_COUNT-1:0] ol_clr;
      reg_sel_e                sel;
      logic [BYTE_BITS-1:0]    status_byte;

      state_d     = state_q;
      sclk_rise   = sclk_s & ~state_q.sclk_prev;
      sclk_fall   = ~sclk_s & state_q.sclk_prev;
      cs_fall     = ~cs_n_s & state_q.cs_n_prev;
      cs_rise     = cs_n_s & ~state_q.cs_n_prev;
      oc_clr      = '0;
      ol_clr      = '0;
      sel         = decode_addr(state_q.rx[FRAME_BITS-1 -: BYTE_BITS]);
      status_byte = STATUS_RESET;
      status_byte[SUMMARY_BIT] = state_q.summary;

      state_d.sclk_prev = sclk_s;
      state_d.cs_n_prev = cs_n_s;

      // link framing; status byte goes out while the address byte comes in
      case (state_q.link)
         LINK_IDLE: begin
            if (cs_fall) begin
               state_d.link    = LINK_FRAME;
               state_d.bit_cnt = '0;
               state_d.sdo     = status_byte[BYTE_BITS-1];
               state_d.tx      = {status_byte[BYTE_BITS-2:0], 1'b0};
               state_d.sdo_oe  = 1'b1;
            end
         end
         LINK_FRAME: begin
            if (cs_rise) begin
               state_d.link   = LINK_IDLE;
               state_d.sdo_oe = 1'b0;
               state_d.sdo    = 1'b0;
               // only a complete 16-bit frame with the clear select bit acts
               if (state_q.bit_cnt == CNT_W'(FRAME_BITS)
                   && state_q.rx[BYTE_BITS + CLEAR_SEL_BIT]) begin  // RULE11 RULE12
                  case (sel)
                     SEL_OC_LO: oc_clr = bank_mask(1'b0);
                     SEL_OC_HI: oc_clr = bank_mask(1'b1);
                     SEL_OL_LO: ol_clr = bank_mask(1'b0);
                     SEL_OL_HI: ol_clr = bank_mask(1'b1);
                     default:   oc_clr = '0;
                  endcase
               end
            end else begin
               if (sclk_rise) begin
                  state_d.rx = {state_q.rx[FRAME_BITS-2:0], sdi_s};
                  // saturate above a full frame so overlong frames are rejected
                  if (state_q.bit_cnt <= CNT_W'(FRAME_BITS)) begin
                     state_d.bit_cnt = state_q.bit_cnt + CNT_W'(1);
                  end
                  // address byte complete: capture the addressed register
                  if (state_q.bit_cnt == CNT_W'(BYTE_BITS - 1)) begin
                     state_d.tx = read_value(
                        decode_addr({state_q.rx[BYTE_BITS-2:0], sdi_s}),
                        state_q.oc, state_q.ol);  // RULE11
                  end
               end
               if (sclk_fall) begin
                  state_d.sdo = state_q.tx[BYTE_BITS-1];
                  state_d.tx  = {state_q.tx[BYTE_BITS-2:0], 1'b0};
               end
            end
         end
         default: state_d.link = LINK_IDLE;
      endcase

      // a detection in the same cycle as the clear keeps the flag set
      state_d.oc = (state_q.oc & ~oc_clr) | oc_det_s;  // RULE7 RULE12 RULE14
      state_d.ol = (state_q.ol & ~ol_clr) | ol_det_s;  // RULE8 RULE12 RULE14

      // summary follows the flags; it has no clear of its own
      state_d.summary = |{state_d.oc, state_d.ol};  // RULE1 RULE2
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // all flags and the summary come up clear
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q.link      <= LINK_IDLE;
         state_q.sclk_prev <= 1'b0;
         state_q.cs_n_prev <= 1'b1;
         state_q.bit_cnt   <= '0;
         state_q.rx        <= '0;
         state_q.tx        <= STATUS_RESET;
         state_q.oc        <= FLAGS_RESET;  // RULE9 RULE13
         state_q.ol        <= FLAGS_RESET;  // RULE9 RULE13
         state_q.sdo       <= 1'b0;
         state_q.sdo_oe    <= 1'b0;
         state_q.summary   <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // a latched overcurrent holds its switch off until the host clears it
   always_comb begin
      for (int k = 0; k < BRIDGE_COUNT; k++) begin
         high_side_disable_o[k] = state_q.oc[2*k+1];  // RULE7
         low_side_disable_o[k]  = state_q.oc[2*k];    // RULE7
      end
   end

   assign spi_sdo_o            = state_q.sdo;
   assign spi_sdo_oe_o         = state_q.sdo_oe;
   assign load_error_summary_o = state_q.summary;

endmodule

// file: sim/bridge_fault_status_bank_properties.sv
`timescale 1ns/1ns
// ****************************************************************
// port checks on the fault status bank
// ****************************************************************
module bridge_fault_status_bank_properties (
   input  wire logic                                      sys_clk_i,
   input  wire logic                                      reset_n_i,
   input  wire logic                                      spi_cs_n_i,
   input  wire logic                                      spi_sclk_i,
   input  wire logic                                      spi_sdo_o,
   input  wire logic                                      spi_sdo_oe_o,
   input  wire logic [bridge_fault_pkg::SWITCH_COUNT-1:0] overcurrent_detect_i,
   input  wire logic [bridge_fault_pkg::SWITCH_COUNT-1:0] open_load_detect_i,
   input  wire logic [bridge_fault_pkg::BRIDGE_COUNT-1:0] high_side_disable_o,
   input  wire logic [bridge_fault_pkg::BRIDGE_COUNT-1:0] low_side_disable_o,
   input  wire logic                                      load_error_summary_o
);
   import bridge_fault_pkg::*;
   logic [SWITCH_COUNT-1:0] off_w;
   // disables laid out like the detectors: even low side, odd high side
   always_comb begin
      for (int k = 0; k < BRIDGE_COUNT; k++) begin
         off_w[2*k]   = low_side_disable_o[k];
         off_w[2*k+1] = high_side_disable_o[k];
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // a frame ended a few clocks ago, the only moment a clear may land
   sequence s_after_frame;
      spi_cs_n_i && (!$past(spi_cs_n_i, 4) || !$past(spi_cs_n_i, 5));
   endsequence
   sequence s_cs_idle;
      spi_cs_n_i [*5];
   endsequence
   property p_oc_latch;
      &(~$past(overcurrent_detect_i, 3) | off_w);
   endproperty
   a_oc_latch: assert property (p_oc_latch) else $error("overcurrent left switch on");
   property p_off_by_host;
      |($past(off_w) & ~off_w) |-> s_after_frame;
   endproperty
   a_off_by_host: assert property (p_off_by_host) else $error("flag dropped alone");
   property p_sum_oc;
      (off_w != '0) |-> load_error_summary_o;
   endproperty
   a_sum_oc: assert property (p_sum_oc) else $error("summary low with switch off");
   property p_sum_cause;
      $rose(load_error_summary_o) |-> $past(overcurrent_detect_i, 3) != '0
         || $past(open_load_detect_i, 3) != '0;
   endproperty
   a_sum_cause: assert property (p_sum_cause) else $error("summary without fault");
   property p_sum_ro;
      $fell(load_error_summary_o) |-> s_after_frame;
   endproperty
   a_sum_ro: assert property (p_sum_ro) else $error("summary fell alone");
   property p_idle;
      s_cs_idle |-> !spi_sdo_oe_o && !spi_sdo_o;
   endproperty
   a_idle: assert property (p_idle) else $error("data out driven outside frame");
   property p_oe_start;
      $fell(spi_cs_n_i) ##1 !spi_cs_n_i [*2] |-> ##1 spi_sdo_oe_o;
   endproperty
   a_oe_start: assert property (p_oe_start) else $error("data out not enabled");
   property p_sdo_hold;
      spi_sdo_oe_o && $past(spi_sdo_oe_o) && $changed(spi_sdo_o)
         |-> $past(spi_sclk_i, 4) && !$past(spi_sclk_i, 3);
   endproperty
   a_sdo_hold: assert property (p_sdo_hold) else $error("data out moved off edge");
endmodule

bind bridge_fault_status_bank bridge_fault_status_bank_properties i_props (
   .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .spi_cs_n_i(spi_cs_n_i),
   .spi_sclk_i(spi_sclk_i), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o),
   .overcurrent_detect_i(overcurrent_detect_i), .open_load_detect_i(open_load_detect_i),
   .high_side_disable_o(high_side_disable_o), .low_side_disable_o(low_side_disable_o),
   .load_error_summary_o(load_error_summary_o)
);

// file: sim/spi_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// host side of the serial link, mode 0, paced by the system clock
// ****************************************************************
module spi_host_model (
   input  wire logic sys_clk_i,
   input  wire logic spi_sdo_i,
   output logic      spi_cs_n_o,
   output logic      spi_sclk_o,
   output logic      spi_sdi_o
);
   // link clock stands still and low outside frames
   initial begin
      spi_cs_n_o = 1'b1;
      spi_sclk_o = 1'b0;
      spi_sdi_o  = 1'b0;
   end
   // msb first; nb other than 16 makes a malformed frame, hp sets the pace
   task automatic frame(input logic [15:0] cmd, input int nb, input int hp,
                        output logic [15:0] rx);
      rx = 16'h0000;
      spi_cs_n_o = 1'b0;
      repeat (hp) @(negedge sys_clk_i);
      for (int i = 15; i > 15 - nb; i--) begin
         spi_sdi_o = cmd[(i + 16) % 16];
         repeat (hp) @(negedge sys_clk_i);
         rx = {rx[14:0], spi_sdo_i};
         spi_sclk_o = 1'b1;
         repeat (hp) @(negedge sys_clk_i);
         spi_sclk_o = 1'b0;
      end
      repeat (hp) @(negedge sys_clk_i);
      spi_cs_n_o = 1'b1;
      // released line shows the inverse so no stale bit is trusted
      spi_sdi_o = ~spi_sdi_o;
      repeat (2 * hp) @(negedge sys_clk_i);
   endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   import bridge_fault_pkg::*;
   logic                    sys_clk_i = 1'b0;
   logic                    reset_n_i = 1'b0;
   logic                    cs_n, sclk, sdi, sdo, sdo_oe, summary;
   logic [SWITCH_COUNT-1:0] oc_det = '0;
   logic [SWITCH_COUNT-1:0] ol_det = '0;
   logic [BRIDGE_COUNT-1:0] hi_off, lo_off;
   logic [15:0]             rx;
   int                      fails = 0;
   int                      num_checks = 0;
   // read addresses with the extension bit at 0, the only form the bank answers
   localparam logic [7:0]   RD [4] = '{8'h59, 8'h39, 8'h05, 8'h45};
   // ****************************************************************
   // clock, device and host
   // ****************************************************************
   always #20 sys_clk_i = ~sys_clk_i;
   bridge_fault_status_bank i_bridge_fault_status_bank (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .spi_cs_n_i(cs_n),
      .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
      .overcurrent_detect_i(oc_det), .open_load_detect_i(ol_det),
      .high_side_disable_o(hi_off), .low_side_disable_o(lo_off),
      .load_error_summary_o(summary));
   spi_host_model i_spi_host_model (.sys_clk_i(sys_clk_i), .spi_sdo_i(sdo),
      .spi_cs_n_o(cs_n), .spi_sclk_o(sclk), .spi_sdi_o(sdi));
   // ****************************************************************
   // shared helpers
   // ****************************************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] adr, input int nb = 16, input int hp = 4);
      i_spi_host_model.frame({adr, 8'h00}, nb, hp, rx);
   endtask
   // short detector pulse: the flag must outlive it
   task automatic pulse(input logic [11:0] oc, input logic [11:0] ol);
      oc_det = oc;
      ol_det = ol;
      repeat (2) @(negedge sys_clk_i);
      oc_det = '0;
      ol_det = '0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_after_reset;
      for (int r = 0; r < 4; r++) begin
         cmd(RD[r]);
         chk("reset value", 16'h0000, rx);
      end
      chk("switches after reset", 16'h0000, {4'h0, hi_off, lo_off});
   endtask
   // every flag alone: position, latch, switch off, clear
   task automatic t_each_flag;
      logic [7:0] r;
      for (int k = 0; k < 2; k++) begin
         for (int s = 0; s < 12; s++) begin
            r = RD[2*k + s/8];
            pulse(12'(k == 0) << s, 12'(k == 1) << s);
            cmd(r);
            chk("flag read", {8'h40, 8'(1 << (s % 8))}, rx);
            chk("switch off", 16'(k == 0) << (6*(s%2) + s/2), {4'h0, hi_off, lo_off});
            cmd(r | 8'h80);
            cmd(r);
            chk("after clear", 16'h0000, rx);
         end
      end
   endtask
   task automatic t_all_flags;
      pulse(12'hfff, 12'hfff);
      for (int r = 0; r < 4; r++) begin
         cmd(RD[r]);
         chk("all set", (r % 2) ? 16'h400f : 16'h40ff, rx);
      end
      cmd(8'hd9);
      cmd(8'hb9);
      chk("summary kept", 16'h0001, {15'h0, summary});
      cmd(8'h85);
      cmd(8'hc5);
      chk("summary gone", 16'h0000, {15'h0, summary});
   endtask
   // reset while every flag stands: registers, switches and link come back clear
   task automatic t_mid_reset;
      pulse(12'hfff, 12'hfff);
      repeat (4) @(negedge sys_clk_i);
      chk("switches before reset", 16'h0fff, {4'h0, hi_off, lo_off});
      reset_n_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      chk("switches after mid reset", 16'h0000, {4'h0, hi_off, lo_off});
      chk("summary and enable", 16'h0000, {14'h0, summary, sdo_oe});
      for (int r = 0; r < 4; r++) begin
         cmd(RD[r]);
         chk("mid reset value", 16'h0000, rx);
      end
   endtask
   task automatic t_refuse_and_race;
      pulse(12'h001, 12'h000);
      cmd(8'hd9, 15);
      cmd(8'hd9, 17);
      cmd(8'hdb);
      chk("bad extension", 16'h4000, rx);
      cmd(8'h59);
      chk("refused clear", 16'h4001, rx);
      // one-cycle fault timed to reach the flags in the very cycle of the clear
      fork
         cmd(8'hd9);
         begin
            @(posedge cs_n);
            oc_det = 12'h001;
            @(negedge sys_clk_i);
            oc_det = '0;
         end
      join
      cmd(8'h59);
      chk("set wins", 16'h4001, rx);
      cmd(8'hd9);
      cmd(8'h59);
      chk("race cleared", 16'h0000, rx);
   endtask
   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (16) @(negedge sys_clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      t_after_reset();
      t_each_flag();
      t_all_flags();
      t_mid_reset();
      t_refuse_and_race();
      end_of_test();
   end
   // about three and a half times the expected run of some 14000 clocks
   initial begin
      #2000000;
      fails++;
      end_of_test();
   end
endmodule
